// File: logic/ddr_init_pkg.sv
// Purpose: Shared constants and types for the memory init link.
// Assumes: One 10 MHz system clock drives both ends.
// Notes: Times are kept as printed; cycle counts derive from them.
// Function
// RULE1: Device resets gear-down, PDA, MPS, CAL, parity off
// RULE2: Power-up reset held at least 200 us
// RULE3: CKE low 10 ns before reset release
// RULE4: Wait 500 us after reset before CKE
// RULE5: Device init after reset uses no CK
// RULE6: Clock stable max(10 ns, 5 tCK) before CKE
// RULE7: Deselect presented on first CKE-high edge
// RULE8: CKE stays high until init finishes
// RULE9: ODT high-Z in reset until CKE high
// RULE10: ODT static after CKE; low if RTT_NOM
// RULE11: Wait tXPR after CKE before first MRS
// RULE12: Load MR3,6,5,4,2,1 with tMRD, MR0 tMOD
// RULE13: Long ZQ, then wait tDLLK and tZQINIT
// RULE14: Only deselects between init commands
// RULE15: Write every defined mode register, DLL order
// RULE16: Test enable held low during init
// RULE17: Stable-power reset 100 ns, CKE low first
// RULE18: Access is activate then read or write
// RULE19: Burst eight or chop four, A12 on fly
// RULE20: One 8n word as eight half-clock beats
// RULE21: Waits counted in rounded-up clock cycles
package ddr_init_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned T_RST_PWR_US = 200;
  localparam int unsigned T_RST_STBL_NS = 100;
  localparam int unsigned T_POST_RST_US = 500;
  localparam int unsigned T_CK_STABLE_NS = 10;
  localparam int unsigned CK_STABLE_TCK = 5;
  localparam int unsigned TXPR_TCK = 5;
  localparam int unsigned RST_PWR_CYC = (T_RST_PWR_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_STBL_CYC = (T_RST_STBL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POST_RST_CYC = (T_POST_RST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CK_NS_CYC = (T_CK_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CK_STABLE_CYC = CK_NS_CYC > CK_STABLE_TCK ? CK_NS_CYC : CK_STABLE_TCK;
  // Plain defaults for device timings that vary by speed grade
  localparam int unsigned TXS_CYC = 5;
  localparam int unsigned TMRD_CYC = 8;
  localparam int unsigned TMOD_CYC = 24;
  localparam int unsigned TDLLK_CYC = 768;
  localparam int unsigned TZQINIT_CYC = 1024;
  localparam int unsigned TRCD_CYC = 2;
  localparam int unsigned INT_INIT_CYC = 16;
  localparam int unsigned CNT_W = 16;
  // Link widths
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned MR_W = 18;
  localparam int unsigned NUM_MR = 7;
  // Mode register fields
  localparam logic [MR_W-1:0] MR_RST = 18'h00000;
  localparam int unsigned MR3_GEARDOWN_BIT = 3;
  localparam int unsigned MR3_PDA_BIT = 4;
  localparam int unsigned MR4_MPS_BIT = 1;
  localparam int unsigned MR4_CAL_LSB = 6;
  localparam int unsigned MR5_PAR_LSB = 0;
  localparam int unsigned MR0_BL_LSB = 0;
  localparam int unsigned MR1_RTT_LSB = 8;
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIX4 = 2'h2;
  localparam int unsigned BL_SEL_BIT = 12;
  localparam int unsigned AP_BIT = 10;
  localparam int unsigned ZQ_LONG_BIT = 10;
  localparam logic [2:0] MR_ORDER [NUM_MR] = '{3'h3, 3'h6, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};
  localparam logic [2:0] MR_LAST_IDX = 3'h6;
  typedef enum logic [2:0] {
    CMD_DES = 3'h0,
    CMD_MRS = 3'h1,
    CMD_ZQCL = 3'h2,
    CMD_ACT = 3'h3,
    CMD_RD = 3'h4,
    CMD_WR = 3'h5
  } cmd_t;
endpackage

// File: logic/ddr_link_if.sv
// Purpose: Command, control and data wires between controller and memory.
// Assumes: Both ends run on the same system clock.
// Notes: Each data beat pair is resolved from the two enables here.
`timescale 1ns/1ps
`default_nettype none
interface ddr_link_if #(parameter int DQ_W = 8);
  logic reset_n;
  logic ck_run;
  logic cke;
  logic odt;
  logic ten;
  ddr_init_pkg::cmd_t cmd;
  logic [1:0] bg;
  logic [1:0] ba;
  logic [ddr_init_pkg::ADDR_W-1:0] addr;
  logic [2*DQ_W-1:0] ctl_dq_o;
  logic ctl_dq_oe_n;
  logic [2*DQ_W-1:0] dev_dq_o;
  logic dev_dq_oe_n;
  logic [2*DQ_W-1:0] dq;
  // Idle bus reads as zero; controller wins a clash
  assign dq = !ctl_dq_oe_n ? ctl_dq_o : (!dev_dq_oe_n ? dev_dq_o : '0);
  modport ctl (output reset_n, ck_run, cke, odt, ten, cmd, bg, ba, addr,
               output ctl_dq_o, ctl_dq_oe_n, input dq);
  modport dev (input reset_n, ck_run, cke, odt, ten, cmd, bg, ba, addr,
               output dev_dq_o, dev_dq_oe_n, input dq);
endinterface
`default_nettype wire

// File: logic/ddr_init_ctl.sv
// Purpose: Controller end: reset, init sequence and single accesses.
// Assumes: Mode register values come flat, 18 bits per register index.
// Notes: Every wait but the clock-run age is a down-counter; a step moves only at zero.
`timescale 1ns/1ps
`default_nettype none
module ddr_init_ctl #(
  parameter int DQ_W = 8,
  parameter int unsigned POST_RST_CYC = ddr_init_pkg::POST_RST_CYC,
  parameter int unsigned TXS_CYC = ddr_init_pkg::TXS_CYC,
  parameter int unsigned TMRD_CYC = ddr_init_pkg::TMRD_CYC,
  parameter int unsigned TMOD_CYC = ddr_init_pkg::TMOD_CYC,
  parameter int unsigned TDLLK_CYC = ddr_init_pkg::TDLLK_CYC,
  parameter int unsigned TZQINIT_CYC = ddr_init_pkg::TZQINIT_CYC,
  parameter int unsigned TRCD_CYC = ddr_init_pkg::TRCD_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_reinit,
  input wire logic [7*ddr_init_pkg::MR_W-1:0] i_mr_flat,
  input wire logic i_odt_level,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic i_bc4,
  input wire logic i_ap,
  input wire logic [1:0] i_bg,
  input wire logic [1:0] i_ba,
  input wire logic [15:0] i_row,
  input wire logic [9:0] i_col,
  input wire logic [8*DQ_W-1:0] i_wdata,
  output logic o_init_done,
  output logic o_ack,
  output logic o_rvalid,
  output logic [8*DQ_W-1:0] o_rdata,
  ddr_link_if.ctl link
);
  localparam int unsigned CW = ddr_init_pkg::CNT_W;
  localparam int unsigned MW = ddr_init_pkg::MR_W;
  localparam int unsigned XPR = TXS_CYC > ddr_init_pkg::TXPR_TCK ? TXS_CYC : ddr_init_pkg::TXPR_TCK;
  localparam int unsigned ZQW = TDLLK_CYC > TZQINIT_CYC ? TDLLK_CYC : TZQINIT_CYC;
  localparam int unsigned WW = 8 * DQ_W;
  localparam int unsigned BW = 2 * DQ_W;

  typedef enum logic [10:0] {
    S_RST = 11'h001,
    S_POST = 11'h002,
    S_XPR = 11'h004,
    S_MRS = 11'h008,
    S_MRW = 11'h010,
    S_ZQ = 11'h020,
    S_ZQW = 11'h040,
    S_IDLE = 11'h080,
    S_ACT = 11'h100,
    S_RW = 11'h200,
    S_DATA = 11'h400
  } state_t;

  state_t state_r;
  logic [CW-1:0] wait_r;
  logic [CW-1:0] ck_cnt_r;
  logic [2:0] mr_idx_r;
  logic [2:0] beats_r;
  logic we_r;
  logic bc4_r;
  logic ap_r;
  logic [1:0] bg_r;
  logic [1:0] ba_r;
  logic [9:0] col_r;
  logic [WW-1:0] sh_r;
  logic [WW-1:0] full_nxt;
  logic rtt_nom_on;
  logic wait_done;

  assign wait_done = (wait_r == '0);
  assign rtt_nom_on = |i_mr_flat[1*MW + ddr_init_pkg::MR1_RTT_LSB +: 3];
  assign full_nxt = {link.dq, sh_r[WW-1:BW]};

  // Main sequence; wait_r is loaded with count-1 on each step except the post-reset wait [RULE21]
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      state_r <= S_RST;
      wait_r <= CW'(ddr_init_pkg::RST_PWR_CYC - 1); // [RULE2]
      mr_idx_r <= 3'h0;
      beats_r <= 3'h0;
    end else if (i_reinit && state_r != S_RST) begin
      state_r <= S_RST;
      wait_r <= CW'(ddr_init_pkg::RST_STBL_CYC - 1); // [RULE17]
    end else begin
      if (!wait_done) begin
        wait_r <= wait_r - CW'(1);
      end
      unique case (state_r)
        S_RST: if (wait_done) begin
          state_r <= S_POST;
          wait_r <= CW'(POST_RST_CYC); // Reset pin rises a cycle late, so no -1 [RULE4]
        end
        S_POST: if (wait_done && ck_cnt_r >= CW'(ddr_init_pkg::CK_STABLE_CYC)) begin // [RULE6]
          state_r <= S_XPR;
          wait_r <= CW'(XPR - 1); // [RULE11]
        end
        S_XPR: if (wait_done) begin
          state_r <= S_MRS;
          mr_idx_r <= 3'h0;
        end
        S_MRS: begin
          state_r <= S_MRW;
          // Last load is MR0 and needs the longer settle [RULE12]
          wait_r <= (mr_idx_r == ddr_init_pkg::MR_LAST_IDX) ? CW'(TMOD_CYC - 1)
                                                           : CW'(TMRD_CYC - 1);
        end
        S_MRW: if (wait_done) begin
          if (mr_idx_r == ddr_init_pkg::MR_LAST_IDX) begin
            state_r <= S_ZQ;
          end else begin
            state_r <= S_MRS;
            mr_idx_r <= mr_idx_r + 3'h1; // [RULE15]
          end
        end
        S_ZQ: begin
          state_r <= S_ZQW;
          wait_r <= CW'(ZQW - 1); // [RULE13]
        end
        S_ZQW: if (wait_done) begin
          state_r <= S_IDLE;
        end
        S_IDLE: if (i_req) begin
          state_r <= S_ACT;
        end
        S_ACT: begin
          state_r <= S_RW;
          wait_r <= CW'(TRCD_CYC - 1);
        end
        S_RW: if (wait_done) begin
          state_r <= S_DATA;
          // Extra count covers the idle cycle before the first beat
          beats_r <= bc4_r ? 3'h3 : 3'h5; // [RULE19]
        end
        S_DATA: begin
          beats_r <= beats_r - 3'h1;
          if (beats_r == 3'h1) begin
            state_r <= S_IDLE;
          end
        end
        default: state_r <= S_RST;
      endcase
    end
  end

  // Clock-run age; restarts whenever the link clock is stopped
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n || !link.ck_run) begin
      ck_cnt_r <= '0;
    end else if (ck_cnt_r != '1) begin
      ck_cnt_r <= ck_cnt_r + CW'(1);
    end
  end

  // Request capture
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      we_r <= 1'b0;
      bc4_r <= 1'b0;
      ap_r <= 1'b0;
      bg_r <= 2'h0;
      ba_r <= 2'h0;
      col_r <= 10'h000;
    end else if (state_r == S_IDLE && i_req) begin
      we_r <= i_we;
      bc4_r <= i_bc4;
      ap_r <= i_ap;
      bg_r <= i_bg;
      ba_r <= i_ba;
      col_r <= i_col;
    end
  end

  // Link pins: reset, CKE, clock run, test enable
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      link.reset_n <= 1'b0;
      link.cke <= 1'b0;
      link.ck_run <= 1'b0;
      link.ten <= 1'b0;
    end else begin
      link.ten <= 1'b0; // [RULE16]
      // CKE drops with reset assertion, so it leads release by at least two cycles [RULE3]
      link.reset_n <= !(state_r == S_RST || (i_reinit && state_r != S_RST));
      link.ck_run <= !(state_r == S_RST || i_reinit);
      // Once raised, CKE stays up through ZQ and DLL waits [RULE8]
      if (state_r == S_RST || i_reinit) begin
        link.cke <= 1'b0;
      end else if (state_r == S_POST && wait_done
                   && ck_cnt_r >= CW'(ddr_init_pkg::CK_STABLE_CYC)) begin
        link.cke <= 1'b1;
      end
    end
  end

  // ODT chosen when CKE rises, then frozen
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      link.odt <= 1'b0;
    end else if (state_r == S_POST) begin
      link.odt <= rtt_nom_on ? 1'b0 : i_odt_level; // [RULE10]
    end
  end

  // Command bus; deselect in every cycle without a command [RULE7] [RULE14]
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      link.cmd <= ddr_init_pkg::CMD_DES;
      link.bg <= 2'h0;
      link.ba <= 2'h0;
      link.addr <= '0;
    end else begin
      link.cmd <= ddr_init_pkg::CMD_DES;
      link.bg <= 2'h0;
      link.ba <= 2'h0;
      link.addr <= '0;
      if (!i_reinit) begin
        unique case (state_r)
          S_XPR: if (wait_done) begin
            link.cmd <= ddr_init_pkg::CMD_MRS;
            link.bg <= {1'b0, ddr_init_pkg::MR_ORDER[0][2]};
            link.ba <= ddr_init_pkg::MR_ORDER[0][1:0];
            link.addr <= i_mr_flat[ddr_init_pkg::MR_ORDER[0]*MW +: MW];
          end
          S_MRW: if (wait_done) begin
            if (mr_idx_r == ddr_init_pkg::MR_LAST_IDX) begin
              link.cmd <= ddr_init_pkg::CMD_ZQCL; // [RULE13]
              link.addr[ddr_init_pkg::ZQ_LONG_BIT] <= 1'b1;
            end else begin
              link.cmd <= ddr_init_pkg::CMD_MRS; // [RULE12]
              link.bg <= {1'b0, ddr_init_pkg::MR_ORDER[mr_idx_r + 3'h1][2]};
              link.ba <= ddr_init_pkg::MR_ORDER[mr_idx_r + 3'h1][1:0];
              link.addr <= i_mr_flat[ddr_init_pkg::MR_ORDER[mr_idx_r + 3'h1]*MW +: MW];
            end
          end
          S_IDLE: if (i_req) begin
            link.cmd <= ddr_init_pkg::CMD_ACT; // [RULE18]
            link.bg <= i_bg;
            link.ba <= i_ba;
            link.addr <= {2'h0, i_row};
          end
          S_RW: if (wait_done) begin
            link.cmd <= we_r ? ddr_init_pkg::CMD_WR : ddr_init_pkg::CMD_RD;
            link.bg <= bg_r;
            link.ba <= ba_r;
            link.addr[9:0] <= col_r;
            link.addr[ddr_init_pkg::AP_BIT] <= ap_r;
            link.addr[ddr_init_pkg::BL_SEL_BIT] <= !bc4_r; // [RULE19]
          end
          default: link.cmd <= ddr_init_pkg::CMD_DES;
        endcase
      end
    end
  end

  // Data beats: two per clock, lowest beats first [RULE20]
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      link.ctl_dq_o <= '0;
      link.ctl_dq_oe_n <= 1'b1;
      sh_r <= '0;
      o_rdata <= '0;
      o_rvalid <= 1'b0;
      o_ack <= 1'b0;
    end else begin
      o_rvalid <= 1'b0;
      o_ack <= 1'b0;
      link.ctl_dq_oe_n <= 1'b1;
      if (state_r == S_RW && wait_done) begin
        // Beats follow the command by one cycle, as the memory expects
        sh_r <= i_wdata;
      end else if (state_r == S_DATA) begin
        if (we_r) begin
          sh_r <= sh_r >> BW;
          link.ctl_dq_o <= sh_r[BW-1:0];
          link.ctl_dq_oe_n <= (beats_r == 3'h1);
        end else begin
          sh_r <= full_nxt;
        end
        if (beats_r == 3'h1) begin
          o_ack <= 1'b1;
          o_rvalid <= !we_r;
          // A chopped read lands in the upper half of the shifter
          o_rdata <= bc4_r ? (full_nxt >> (4 * DQ_W)) : full_nxt;
        end
      end
    end
  end

  // Init status
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_init_done <= 1'b0;
    end else begin
      o_init_done <= !i_reinit && (state_r == S_IDLE || state_r == S_ACT
                     || state_r == S_RW || state_r == S_DATA
                     || (state_r == S_ZQW && wait_done));
    end
  end
endmodule
`default_nettype wire

// File: logic/ddr_init_dev.sv
// Purpose: Memory end: reset defaults, ODT state, mode load, bursts.
// Assumes: Row address is not stored; words are indexed by bank and column.
// Notes: Commands count only after CKE has been seen high since reset.
`timescale 1ns/1ps
`default_nettype none
module ddr_init_dev #(
  parameter int DQ_W = 8,
  parameter int DEP_W = 11,
  parameter int unsigned INT_INIT_CYC = ddr_init_pkg::INT_INIT_CYC,
  parameter int unsigned TDLLK_CYC = ddr_init_pkg::TDLLK_CYC,
  parameter int unsigned TZQINIT_CYC = ddr_init_pkg::TZQINIT_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  output logic o_ready,
  output logic o_odt_hiz,
  output logic o_rtt_on,
  output logic o_cmd_err,
  ddr_link_if.dev link
);
  localparam int unsigned CW = ddr_init_pkg::CNT_W;
  localparam int unsigned MW = ddr_init_pkg::MR_W;
  localparam int unsigned WW = 8 * DQ_W;
  localparam int unsigned BW = 2 * DQ_W;

  logic rst;
  logic live;
  logic cke_seen_r;
  logic [CW-1:0] init_r;
  logic [CW-1:0] dll_r;
  logic [CW-1:0] zq_r;
  logic [MW-1:0] mr_r [ddr_init_pkg::NUM_MR];
  logic [15:0] open_r;
  logic [WW-1:0] mem [2**DEP_W];
  logic [DEP_W-1:0] idx;
  logic [DEP_W-1:0] widx_r;
  logic [3:0] bank;
  logic [1:0] bl_mode;
  logic chop;
  logic [2:0] rbeats_r;
  logic [2:0] wbeats_r;
  logic wchop_r;
  logic [WW-1:0] rsh_r;
  logic [WW-1:0] wsh_r;
  logic [WW-1:0] wfull;

  assign rst = !i_reset_n || !link.reset_n;
  assign live = cke_seen_r && link.cke && link.ck_run && init_r == '0;
  assign bank = {link.bg, link.ba};
  assign idx = DEP_W'({bank, link.addr[9:3]});
  assign bl_mode = mr_r[0][ddr_init_pkg::MR0_BL_LSB +: 2];
  // On-the-fly chop only when MR0 allows it; A12 high asks eight [RULE19]
  assign chop = (bl_mode == ddr_init_pkg::BL_FIX4)
             || (bl_mode == ddr_init_pkg::BL_OTF && !link.addr[ddr_init_pkg::BL_SEL_BIT]);
  assign wfull = {link.dq, wsh_r[WW-1:BW]};

  // Internal init runs on the device's own clock, CK may be stopped [RULE5]
  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      init_r <= CW'(INT_INIT_CYC);
    end else if (init_r != '0) begin
      init_r <= init_r - CW'(1);
    end
  end

  // CKE capture; termination stays off until then [RULE9]
  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      cke_seen_r <= 1'b0;
      o_odt_hiz <= 1'b1;
      o_rtt_on <= 1'b0;
    end else begin
      if (link.cke && link.ck_run) begin
        cke_seen_r <= 1'b1;
      end
      o_odt_hiz <= !(cke_seen_r || (link.cke && link.ck_run));
      o_rtt_on <= cke_seen_r && link.odt
                  && |mr_r[1][ddr_init_pkg::MR1_RTT_LSB +: 3];
    end
  end

  // Mode registers reset with all listed features off [RULE1]
  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      for (int i = 0; i < ddr_init_pkg::NUM_MR; i++) begin
        mr_r[i] <= ddr_init_pkg::MR_RST;
      end
    end else if (live && link.cmd == ddr_init_pkg::CMD_MRS && {link.bg[0], link.ba} != 3'h7) begin
      mr_r[{link.bg[0], link.ba}] <= link.addr;
    end
  end

  // DLL lock from MR0 load and ZQ from long calibration
  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      // All-ones parks each count until its command arrives
      dll_r <= '1;
      zq_r <= '1;
      o_ready <= 1'b0;
    end else begin
      if (live && link.cmd == ddr_init_pkg::CMD_MRS && {link.bg[0], link.ba} == 3'h0) begin
        dll_r <= CW'(TDLLK_CYC);
      end else if (dll_r != '0 && dll_r != '1) begin
        dll_r <= dll_r - CW'(1);
      end
      if (live && link.cmd == ddr_init_pkg::CMD_ZQCL) begin
        zq_r <= CW'(TZQINIT_CYC);
      end else if (zq_r != '0 && zq_r != '1 && !o_ready) begin
        zq_r <= zq_r - CW'(1);
      end
      o_ready <= o_ready || (dll_r == '0 && zq_r == '0 && cke_seen_r);
    end
  end

  // Row state: activate opens, auto-precharge closes [RULE18]
  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      open_r <= 16'h0000;
      o_cmd_err <= 1'b0;
    end else if (live) begin
      if (link.cmd == ddr_init_pkg::CMD_ACT) begin
        open_r[bank] <= 1'b1;
      end else if (link.cmd == ddr_init_pkg::CMD_RD || link.cmd == ddr_init_pkg::CMD_WR) begin
        if (!open_r[bank] || !o_ready) begin
          o_cmd_err <= 1'b1;
        end
        if (link.addr[ddr_init_pkg::AP_BIT]) begin
          open_r[bank] <= 1'b0;
        end
      end
    end
  end

  // Read burst: one core word out as two beats per clock [RULE20]
  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      rbeats_r <= 3'h0;
      rsh_r <= '0;
      link.dev_dq_o <= '0;
      link.dev_dq_oe_n <= 1'b1;
    end else if (live && link.cmd == ddr_init_pkg::CMD_RD) begin
      rbeats_r <= chop ? 3'h1 : 3'h3;
      rsh_r <= mem[idx] >> BW;
      link.dev_dq_o <= mem[idx][BW-1:0];
      link.dev_dq_oe_n <= 1'b0;
    end else if (rbeats_r != 3'h0) begin
      rbeats_r <= rbeats_r - 3'h1;
      rsh_r <= rsh_r >> BW;
      link.dev_dq_o <= rsh_r[BW-1:0];
    end else begin
      link.dev_dq_oe_n <= 1'b1;
    end
  end

  // Write burst capture; a chop keeps the upper half of the word
  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      wbeats_r <= 3'h0;
      wchop_r <= 1'b0;
      widx_r <= '0;
      wsh_r <= '0;
    end else if (live && link.cmd == ddr_init_pkg::CMD_WR) begin
      wbeats_r <= chop ? 3'h2 : 3'h4;
      wchop_r <= chop;
      widx_r <= idx;
    end else if (wbeats_r != 3'h0) begin
      wbeats_r <= wbeats_r - 3'h1;
      wsh_r <= wfull;
    end
  end

  // Core array write at the last beat
  always_ff @(posedge i_clk_sys) begin
    if (wbeats_r == 3'h1) begin
      if (wchop_r) begin
        mem[widx_r][WW/2-1:0] <= wfull[WW-1:WW/2];
      end else begin
        mem[widx_r] <= wfull;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/ddr_init_checker.sv
// Purpose: Link checks for the init sequence between both ends.
// Assumes: One system clock; the shrunk post-reset wait handed in as a parameter.
// Notes: Mode load order is checked only from a fresh MR3 load.
`timescale 1ns/1ps
`default_nettype none
module ddr_init_checker #(parameter int unsigned POST_RST_CYC = 10) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic reset_n,
  input wire logic ck_run,
  input wire logic cke,
  input wire logic odt,
  input wire logic ten,
  input wire ddr_init_pkg::cmd_t cmd,
  input wire logic [1:0] bg,
  input wire logic [1:0] ba,
  input wire logic [ddr_init_pkg::ADDR_W-1:0] addr
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  logic [15:0] wait_r;
  logic [2:0] mr_sel;
  logic mrs_v;
  assign mr_sel = {bg[0], ba};
  assign mrs_v = cmd == ddr_init_pkg::CMD_MRS;
  // Counts released-reset cycles with cke low; saturates so it never wraps
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n || !reset_n) wait_r <= '0;
    else if (!cke && wait_r != 16'hFFFF) wait_r <= wait_r + 16'h1;
  end
  property p_cke_reset; !reset_n |-> !cke; endproperty
  a_cke_reset: assert property (p_cke_reset) else $error("cke high in reset");
  property p_post_wait; $rose(cke) |-> wait_r >= POST_RST_CYC; endproperty
  a_post_wait: assert property (p_post_wait) else $error("cke early");
  property p_ck_first; $rose(cke) |-> $past(ck_run, 5); endproperty
  a_ck_first: assert property (p_ck_first) else $error("clock not stable");
  property p_cke_hold; cke && reset_n |=> cke || !reset_n; endproperty
  a_cke_hold: assert property (p_cke_hold) else $error("cke dropped");
  property p_xpr; $rose(cke) |-> (cmd == ddr_init_pkg::CMD_DES)[*5] ##1 mrs_v; endproperty
  a_xpr: assert property (p_xpr) else $error("first mode load spacing");
  property p_odt_static; $rose(cke) |=> $stable(odt)[*8]; endproperty
  a_odt_static: assert property (p_odt_static) else $error("odt moved");
  property p_mr_order;
    mrs_v && mr_sel == 3'h3 |-> ##9 mrs_v && mr_sel == 3'h6 ##9 mrs_v && mr_sel == 3'h5
      ##9 mrs_v && mr_sel == 3'h4 ##9 mrs_v && mr_sel == 3'h2 ##9 mrs_v && mr_sel == 3'h1
      ##9 mrs_v && mr_sel == 3'h0 ##25 cmd == ddr_init_pkg::CMD_ZQCL && addr[10];
  endproperty
  a_mr_order: assert property (p_mr_order) else $error("mode load order");
  property p_des_gap; mrs_v |=> (cmd == ddr_init_pkg::CMD_DES)[*7]; endproperty
  a_des_gap: assert property (p_des_gap) else $error("command in mode gap");
  property p_ten_low; !ten; endproperty
  a_ten_low: assert property (p_ten_low) else $error("test enable high");
  c_cke: cover property ($rose(cke));
  c_zq: cover property (cmd == ddr_init_pkg::CMD_ZQCL);
  c_rd: cover property (cmd == ddr_init_pkg::CMD_RD);
  c_wr: cover property (cmd == ddr_init_pkg::CMD_WR);
endmodule
`default_nettype wire

// File: tb/ddr4_reset_init_sequence_tb_top.sv
// Purpose: Drives both ends through init, accesses and a re-init.
// Assumes: Shrunk post-reset wait in the controller; DLL and ZQ waits shrunk in both ends.
// Notes: Rows hold expected words; reads follow the writes that fill them.
`timescale 1ns/1ps
`default_nettype none
module ddr4_reset_init_sequence_tb_top;
  localparam int unsigned SHORT = 20;
  typedef struct packed {
    logic we; logic bc4; logic [1:0] bg; logic [1:0] ba; logic [9:0] col; logic [63:0] d;
  } row_t;
  logic i_clk_sys = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_reinit = 1'b0;
  logic [7*ddr_init_pkg::MR_W-1:0] i_mr_flat = '0;
  logic i_odt_level = 1'b1;
  logic i_req = 1'b0;
  logic i_we = 1'b0;
  logic i_bc4 = 1'b0;
  logic i_ap = 1'b0;
  logic [1:0] i_bg = '0;
  logic [1:0] i_ba = '0;
  logic [15:0] i_row = 16'h0012;
  logic [9:0] i_col = '0;
  logic [63:0] i_wdata = '0;
  logic o_init_done, o_ack, o_rvalid, o_ready, o_odt_hiz, o_rtt_on, o_cmd_err;
  logic [63:0] o_rdata;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  row_t rows [8] = '{
    {1'b1, 1'b0, 2'h0, 2'h1, 10'h008, 64'h0123456789ABCDEF},
    {1'b1, 1'b0, 2'h3, 2'h2, 10'h3F8, 64'hFEDCBA9876543210},
    {1'b0, 1'b0, 2'h0, 2'h1, 10'h008, 64'h0123456789ABCDEF},
    {1'b0, 1'b0, 2'h3, 2'h2, 10'h3F8, 64'hFEDCBA9876543210},
    {1'b1, 1'b1, 2'h0, 2'h1, 10'h008, 64'hAAAAAAAA55555555},
    {1'b0, 1'b0, 2'h0, 2'h1, 10'h008, 64'h0123456755555555},
    {1'b0, 1'b1, 2'h0, 2'h1, 10'h008, 64'h0000000055555555},
    {1'b0, 1'b1, 2'h3, 2'h2, 10'h3F8, 64'h0000000076543210}};
  ddr_link_if #(.DQ_W(8)) link ();
  ddr_init_ctl #(.POST_RST_CYC(10), .TDLLK_CYC(SHORT), .TZQINIT_CYC(SHORT)) u_ddr_init_ctl (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_reinit(i_reinit), .i_mr_flat(i_mr_flat),
    .i_odt_level(i_odt_level), .i_req(i_req), .i_we(i_we), .i_bc4(i_bc4), .i_ap(i_ap),
    .i_bg(i_bg), .i_ba(i_ba), .i_row(i_row), .i_col(i_col), .i_wdata(i_wdata),
    .o_init_done(o_init_done), .o_ack(o_ack), .o_rvalid(o_rvalid), .o_rdata(o_rdata),
    .link(link));
  ddr_init_dev #(.INT_INIT_CYC(8), .TDLLK_CYC(SHORT), .TZQINIT_CYC(SHORT)) u_ddr_init_dev (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .o_ready(o_ready), .o_odt_hiz(o_odt_hiz),
    .o_rtt_on(o_rtt_on), .o_cmd_err(o_cmd_err), .link(link));
  ddr_init_checker #(.POST_RST_CYC(10)) u_ddr_init_checker (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .reset_n(link.reset_n),
    .ck_run(link.ck_run), .cke(link.cke), .odt(link.odt), .ten(link.ten), .cmd(link.cmd),
    .bg(link.bg), .ba(link.ba), .addr(link.addr));
  // Half period of 50 ns gives the 10 MHz system clock
  always #50 i_clk_sys = ~i_clk_sys;
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic tick();
    @(posedge i_clk_sys);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("TB: errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Bounded wait so a stuck sequence shows as a mismatch, not a hang
  task automatic wait_init();
    int n;
    n = 0;
    while (!o_init_done && n < 2400) begin
      tick();
      n++;
    end
    chk("init_done", 1'b1, o_init_done);
  endtask
  // One request cycle; clocks with beats on the data bus are counted until the ack
  task automatic access(input row_t r);
    int n;
    int beats;
    logic [15:0] first;
    n = 0;
    beats = 0;
    first = '0;
    {i_we, i_bc4, i_bg, i_ba, i_col, i_wdata} = {r.we, r.bc4, r.bg, r.ba, r.col, r.d};
    i_req = 1'b1;
    tick();
    i_req = 1'b0;
    while (o_ack !== 1'b1 && n < 20) begin
      if (link.cmd == ddr_init_pkg::CMD_RD || link.cmd == ddr_init_pkg::CMD_WR)
        chk("burst_sel", !r.bc4, link.addr[12]);
      if (!link.ctl_dq_oe_n || !link.dev_dq_oe_n) begin
        if (beats == 0) first = link.dq;
        beats++;
      end
      tick();
      n++;
    end
    chk("ack", 1'b1, o_ack);
    chk("beat_clocks", r.bc4 ? 2 : 4, beats);
    chk("first_beats", r.d[15:0], first);
    if (!r.we) chk("rdata", r.d, o_rdata);
    if (!r.we) chk("rvalid", 1'b1, o_rvalid);
  endtask
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 8000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    i_mr_flat[1:0] = ddr_init_pkg::BL_OTF;
    repeat (6) tick();
    chk("odt_hiz", 1'b1, o_odt_hiz);
    i_reset_n = 1'b1;
    while (!link.reset_n && cyc < 2100) tick();
    chk("odt_hiz_post", 1'b1, o_odt_hiz);
    chk("cke_post", 1'b0, link.cke);
    wait_init();
    tick(); // Device ready registers a cycle after the controller's wait
    chk("ready", 1'b1, o_ready);
    chk("odt_hiz_done", 1'b0, o_odt_hiz);
    chk("odt_level", 1'b1, link.odt);
    foreach (rows[i]) access(rows[i]);
    // Re-init with termination enabled: odt must now be held low
    i_mr_flat[ddr_init_pkg::MR_W + ddr_init_pkg::MR1_RTT_LSB +: 3] = 3'h1;
    i_reinit = 1'b1;
    tick();
    i_reinit = 1'b0;
    tick();
    chk("reinit_ready", 1'b0, o_ready);
    wait_init();
    chk("odt_rtt", 1'b0, link.odt);
    chk("rtt_on", 1'b0, o_rtt_on);
    chk("cmd_err", 1'b0, o_cmd_err);
    tally_and_finish();
  end
endmodule
`default_nettype wire
